// *** core/gauge_control_status_register.v ***
// Purpose : control and status register of the battery gauge
// Assumes : reg_addr/reg_wdata/reg_wr/reg_rd come from the serial slave,
//           one-cycle strobes synchronous to core_clk
// Notes   : rst is the power-on reset; soft reset is an output
`include "gauge_ctrl_consts.vh"
`default_nettype none
module gauge_control_status_register (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire       alarm_function_enable,
  input  wire       cur_conv_end,
  input  wire       volt_conv_end,
  input  wire       low_charge_cond,
  input  wire       low_voltage_cond,
  input  wire       alarm_pin_in,
  output reg  [7:0] reg_rdata,
  output reg        alarm_pin_out,
  output reg        alarm_pin_oe_n,
  output reg        accumulator_clear,
  output reg        soft_reset
);
  // decoded strobes and qualified alarm events
  wire       hit_wr;
  wire       hit_rd;
  wire       low_charge_ev;
  wire       low_voltage_ev;
  wire       low_charge_clr;
  wire       low_voltage_clr;
  wire       pull_low;

  // register state beside its next value
  reg        alarm_pin_drive_reg;
  reg        alarm_pin_drive_next;
  reg        power_on_detect_reg;
  reg        power_on_detect_next;
  reg        current_conv_done_reg;
  reg        current_conv_done_next;
  reg        voltage_conv_done_reg;
  reg        voltage_conv_done_next;
  reg        low_charge_alarm_flag_reg;
  reg        low_charge_alarm_flag_next;
  reg        low_voltage_alarm_flag_reg;
  reg        low_voltage_alarm_flag_next;
  reg        soft_reset_next;
  reg        accumulator_clear_next;
  reg        alarm_pin_oe_n_next;
  reg  [7:0] rdata_next;

  // one decoder serves both strobes, so read and write share an address
  function ctrl_hit(input strobe, input [7:0] addr);
    ctrl_hit = strobe && (addr == `CTRL_ADDR);
  endfunction

  // set beats clear, so an event in the clearing cycle is never lost
  function flag_update(input cur, input set, input clr);
    flag_update = set ? 1'b1 : (clr ? 1'b0 : cur);
  endfunction

  // bits 1 and 7 have no read source and always return 0
  function [7:0] status_byte(input pin_level, input cur_done,
                             input volt_done, input por,
                             input low_charge, input low_voltage);
    status_byte = ({7'h00, pin_level}   << `BIT_PIN_LEVEL)   |
                  ({7'h00, cur_done}    << `BIT_CUR_DONE)    |
                  ({7'h00, volt_done}   << `BIT_VOLT_DONE)   |
                  ({7'h00, por}         << `BIT_POR_DETECT)  |
                  ({7'h00, low_charge}  << `BIT_LOW_CHARGE)  |
                  ({7'h00, low_voltage} << `BIT_LOW_VOLTAGE);
  endfunction

  assign hit_wr = ctrl_hit(reg_wr, reg_addr);
  assign hit_rd = ctrl_hit(reg_rd, reg_addr);

  // alarm conditions are ignored unless the mode register enables them
  assign low_charge_ev  = alarm_function_enable && low_charge_cond;
  assign low_voltage_ev = alarm_function_enable && low_voltage_cond;

  // writing 1 to an alarm bit keeps it; only a written 0 clears
  assign low_charge_clr  = hit_wr && !reg_wdata[`BIT_LOW_CHARGE];
  assign low_voltage_clr = hit_wr && !reg_wdata[`BIT_LOW_VOLTAGE];

  // open drain: the pin is only ever pulled low, never driven high
  assign pull_low = !alarm_pin_drive_reg || low_charge_alarm_flag_reg ||
                    low_voltage_alarm_flag_reg;

  always @* begin
    rdata_next = reg_rdata;
    if (hit_rd)
      rdata_next = status_byte(alarm_pin_in, current_conv_done_reg,
                               voltage_conv_done_reg, power_on_detect_reg,
                               low_charge_alarm_flag_reg,
                               low_voltage_alarm_flag_reg);
  end

  always @* begin
    alarm_pin_drive_next = alarm_pin_drive_reg;
    power_on_detect_next = power_on_detect_reg;
    soft_reset_next      = soft_reset;
    if (hit_wr) begin
      alarm_pin_drive_next = reg_wdata[`BIT_PIN_DRIVE];
      power_on_detect_next = reg_wdata[`BIT_POR_DETECT];
      soft_reset_next      = reg_wdata[`BIT_POR_DETECT];
    end
  end

  // the clear is a one-cycle pulse, so the bit behaves as self-clearing
  always @* begin
    accumulator_clear_next = hit_wr && reg_wdata[`BIT_ACC_CLEAR];
  end

  // a completion in the read cycle survives the read-clear
  always @* begin
    current_conv_done_next = flag_update(current_conv_done_reg,
                                         cur_conv_end, hit_rd);
  end

  always @* begin
    voltage_conv_done_next = flag_update(voltage_conv_done_reg,
                                         volt_conv_end, hit_rd);
  end

  // a held condition keeps its flag set through a clearing write while alarm_function_enable is high
  always @* begin
    low_charge_alarm_flag_next = flag_update(low_charge_alarm_flag_reg,
                                             low_charge_ev,
                                             low_charge_clr);
  end

  always @* begin
    low_voltage_alarm_flag_next = flag_update(low_voltage_alarm_flag_reg,
                                              low_voltage_ev,
                                              low_voltage_clr);
  end

  always @* begin
    alarm_pin_oe_n_next = !pull_low;
  end

  // read data is taken at the read edge and held until the next read hit
  always @(posedge core_clk) begin
    if (rst)
      reg_rdata <= `RST_RDATA;
    else
      reg_rdata <= rdata_next;
  end

  always @(posedge core_clk) begin
    if (rst)
      alarm_pin_drive_reg <= `RST_PIN_DRIVE;
    else
      alarm_pin_drive_reg <= alarm_pin_drive_next;
  end

  // the power-on reset or a write with bit 4 set sets this; soft reset leaves the register alone
  always @(posedge core_clk) begin
    if (rst)
      power_on_detect_reg <= `RST_POR_DETECT;
    else
      power_on_detect_reg <= power_on_detect_next;
  end

  // soft reset is a level for the rest of the device to act on
  always @(posedge core_clk) begin
    if (rst)
      soft_reset <= `RST_FLAG;
    else
      soft_reset <= soft_reset_next;
  end

  always @(posedge core_clk) begin
    if (rst)
      accumulator_clear <= `RST_FLAG;
    else
      accumulator_clear <= accumulator_clear_next;
  end

  always @(posedge core_clk) begin
    if (rst)
      current_conv_done_reg <= `RST_FLAG;
    else
      current_conv_done_reg <= current_conv_done_next;
  end

  always @(posedge core_clk) begin
    if (rst)
      voltage_conv_done_reg <= `RST_FLAG;
    else
      voltage_conv_done_reg <= voltage_conv_done_next;
  end

  always @(posedge core_clk) begin
    if (rst)
      low_charge_alarm_flag_reg <= `RST_FLAG;
    else
      low_charge_alarm_flag_reg <= low_charge_alarm_flag_next;
  end

  always @(posedge core_clk) begin
    if (rst)
      low_voltage_alarm_flag_reg <= `RST_FLAG;
    else
      low_voltage_alarm_flag_reg <= low_voltage_alarm_flag_next;
  end

  // registered enable keeps the pin free of decode glitches
  always @(posedge core_clk) begin
    if (rst)
      alarm_pin_oe_n <= `RST_PIN_OE_N;
    else
      alarm_pin_oe_n <= alarm_pin_oe_n_next;
  end

  // the pin never sees a high drive; the pull-up supplies the high level
  always @(posedge core_clk) begin
    if (rst)
      alarm_pin_out <= `RST_FLAG;
    else
      alarm_pin_out <= 1'b0;
  end
endmodule
`default_nettype wire

// *** shared/gauge_ctrl_consts.vh ***
// Purpose : constants of the gauge control/status register
// Assumes : register port decoded by the serial slave logic
// Notes   : definitions only
`ifndef GAUGE_CTRL_CONSTS_VH
`define GAUGE_CTRL_CONSTS_VH
`define CTRL_ADDR        8'h01
`define BIT_PIN_LEVEL    0
`define BIT_PIN_DRIVE    0
`define BIT_ACC_CLEAR    1
`define BIT_CUR_DONE     2
`define BIT_VOLT_DONE    3
`define BIT_POR_DETECT   4
`define BIT_LOW_CHARGE   5
`define BIT_LOW_VOLTAGE  6
`define RST_PIN_DRIVE    1'b1
`define RST_POR_DETECT   1'b1
`define RST_RDATA        8'h00
`define RST_FLAG         1'b0
`define RST_PIN_OE_N     1'b1
`endif

// *** verif/alarm_pin_pullup.sv ***
// Purpose: alarm pin wire model. Assumes: external pull-up. Notes: none
`default_nettype none
module alarm_pin_pullup (input wire logic alarm_pin_out, alarm_pin_oe_n,
  output logic alarm_pin_in);
  timeunit 1ns;
  timeprecision 1ns;
  // a released open-drain pin floats up to the pull-up level
  assign alarm_pin_in = alarm_pin_oe_n ? 1'b1 : alarm_pin_out;
endmodule
`default_nettype wire

// *** verif/gauge_control_status_register_test.sv ***
// Purpose: register bench. Assumes: pull-up pin. Notes: none
`default_nettype none
module gauge_control_status_register_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ena = 0, cce = 0;
  logic vce = 0, lcc = 0, lvc = 0, pin_in, pin_out, pin_oe_n, acc_clr, srst;
  logic [7:0] reg_addr = 8'h01, reg_wdata = 8'h00, reg_rdata;
  int errors = 0, samples_checked = 0;
  always #20 core_clk = ~core_clk;
  gauge_control_status_register dut (.core_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .alarm_function_enable(ena), .cur_conv_end(cce),
    .volt_conv_end(vce), .low_charge_cond(lcc), .low_voltage_cond(lvc),
    .alarm_pin_in(pin_in), .reg_rdata, .alarm_pin_out(pin_out),
    .alarm_pin_oe_n(pin_oe_n), .accumulator_clear(acc_clr), .soft_reset(srst));
  alarm_pin_pullup pin (.alarm_pin_out(pin_out), .alarm_pin_oe_n(pin_oe_n),
    .alarm_pin_in(pin_in));
  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp);
    samples_checked++;
    if (reg_rdata !== exp) begin
      errors++;
      $display("mismatch reg_rdata exp %h got %h", exp, reg_rdata);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge core_clk);
    {reg_wr, reg_rd} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] exp);
    acc(0, 8'h01, 8'h00);
    chk(exp);
  endtask
  // one idle edge also lets the registered pin enable settle before a read
  task automatic pulse(input logic [3:0] v);
    @(negedge core_clk);
    {cce, vce, lcc, lvc} = v;
    @(negedge core_clk);
    {cce, vce, lcc, lvc} = 4'h0;
  endtask
  initial begin
    #20000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (20) @(negedge core_clk);
    rst = 0;
    rd(8'h11);
    pulse(4'hc);
    rd(8'h1d);
    rd(8'h11);
    pulse(4'h3);
    rd(8'h11);
    ena = 1;
    pulse(4'h3);
    rd(8'h70);
    acc(1, 8'h01, 8'h31);
    chk_bit("soft_reset", 1'b1, srst);
    chk_bit("accumulator_clear", 1'b0, acc_clr);
    rd(8'h30);
    acc(1, 8'h01, 8'h11);
    pulse(4'h0);
    rd(8'h11);
    acc(1, 8'h01, 8'h02);
    chk_bit("accumulator_clear", 1'b1, acc_clr);
    chk_bit("soft_reset", 1'b0, srst);
    pulse(4'h0);
    chk_bit("accumulator_clear", 1'b0, acc_clr);
    chk_bit("alarm_pin_oe_n", 1'b0, pin_oe_n);
    rd(8'h00);
    acc(1, 8'h02, 8'h11);
    rd(8'h00);
    // live value now differs from the held read data
    acc(1, 8'h01, 8'h11);
    acc(0, 8'h02, 8'h00);
    chk(8'h00);
    rd(8'h11);
    print_verdict;
  end
endmodule
`default_nettype wire

// *** verif/gauge_ctrl_assertions.sv ***
// Purpose: register checks. Assumes: bound to dut. Notes: none
`default_nettype none
module gauge_ctrl_chk (input wire logic core_clk, rst, reg_wr, reg_rd,
  alarm_pin_in, cur_conv_end, volt_conv_end, alarm_pin_out, alarm_pin_oe_n,
  accumulator_clear, soft_reset, input wire logic [7:0] reg_addr, reg_wdata,
  reg_rdata);
  timeunit 1ns;
  timeprecision 1ns;
  wire wh = reg_wr && reg_addr == 8'h01;
  wire rh = reg_rd && reg_addr == 8'h01;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // read, an idle cycle with no conversion end, then a second read
  sequence s_rd2;
    rh && !cur_conv_end && !volt_conv_end ##1
    !cur_conv_end && !volt_conv_end ##1 rh;
  endsequence
  sequence s_off; wh && !reg_wdata[0] ##1 !wh; endsequence
  AST_CLR: assert property (accumulator_clear == $past(wh && reg_wdata[1]))
    else $error("clear pulse wrong");
  AST_SR: assert property (wh |=> soft_reset == $past(reg_wdata[4]))
    else $error("soft reset wrong");
  AST_PIN: assert property (rh |=> reg_rdata[0] == $past(alarm_pin_in))
    else $error("pin level wrong");
  AST_HOLD: assert property (!rh |=> $stable(reg_rdata))
    else $error("read data moved");
  AST_FORCE: assert property (s_off |=> !alarm_pin_oe_n)
    else $error("pin not forced");
  AST_OUT: assert property (alarm_pin_out == 1'b0)
    else $error("pin driven high");
  AST_DONE: assert property (s_rd2 |=> reg_rdata[3:2] == 2'b00)
    else $error("done flag not cleared");
  AST_BITS: assert property (rh |=> !reg_rdata[7] && !reg_rdata[1])
    else $error("unused bits set");
endmodule
bind gauge_control_status_register gauge_ctrl_chk chk (.*);
`default_nettype wire
